// ==== bench/pixfix_regs_properties.sv ====
// Purpose: bus-side assertions of the pixel-fix/timing bank
// Assumes: one clock domain, NRST low disables all checks
// Notes:   bound to the design top from tb_top
module pixfix_regs_properties #(
    parameter int TW = 16,
    parameter int LW = 12
) (
    input wire logic          CLK_SYS,
    input wire logic          NRST,
    input wire logic [11:0]   BUS_ADDR,
    input wire logic          BUS_WR,
    input wire logic          BUS_RD,
    input wire logic [31:0]   BUS_WDATA,
    input wire logic          BUS_RVALID,
    input wire logic [LW-1:0] NEIGHBOUR_LIMIT,
    input wire logic [LW-1:0] SAMECOLOUR_LIMIT,
    input wire logic          PIXFIX_ENABLE,
    input wire logic          INTERP_RESET,
    input wire logic [1:0]    MOSAIC_PHASE,
    input wire logic [1:0]    SYNC_POLARITY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_wr(logic [11:0] a);
        BUS_WR && BUS_ADDR == a;
    endsequence
    sequence s_read;
        BUS_RD ##1 BUS_RVALID;
    endsequence

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_answer;
        BUS_RD |-> s_read;
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_quiet;
        !BUS_RD |=> !BUS_RVALID;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without read");
    property p_neigh;
        s_wr(12'h880) |=> NEIGHBOUR_LIMIT == $past(BUS_WDATA[LW-1:0]);
    endproperty
    a_neigh: assert property (p_neigh) else $error("neighbour limit not written");
    property p_keep;
        BUS_WR && BUS_ADDR != 12'h880 |=> $stable(NEIGHBOUR_LIMIT);
    endproperty
    a_keep: assert property (p_keep) else $error("limit changed by other offset");
    property p_same;
        s_wr(12'h884) |=> SAMECOLOUR_LIMIT == $past(BUS_WDATA[LW-1:0]);
    endproperty
    a_same: assert property (p_same) else $error("same-colour limit not written");
    property p_pol;
        s_wr(12'h868) |=> SYNC_POLARITY == $past(BUS_WDATA[1:0]);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not written");
    property p_phase;
        s_wr(12'h86C) |=> MOSAIC_PHASE == $past(BUS_WDATA[1:0]);
    endproperty
    a_phase: assert property (p_phase) else $error("phase not written");
    property p_enable;
        s_wr(12'h878) |=> PIXFIX_ENABLE == $past(BUS_WDATA[0]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable not written");
    property p_ireset;
        s_wr(12'h83C) |=> INTERP_RESET == $past(BUS_WDATA[0]);
    endproperty
    a_ireset: assert property (p_ireset) else $error("soft reset not written");
endmodule : pixfix_regs_properties

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench of the pixel-fix/timing bank
// Assumes: constants from pixfix_consts.svh
// Notes:   reads queue expectations; a monitor compares on BUS_RVALID
`include "pixfix_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TW = 16;
    localparam int LW = 12;
    logic                      clk_sys = 1'b0;
    logic                      nrst = 1'b0;
    logic [11:0]               bus_addr = 12'h000;
    logic                      bus_wr = 1'b0;
    logic                      bus_rd = 1'b0;
    logic [31:0]               bus_wdata = 32'h0;
    logic [31:0]               bus_rdata;
    logic                      bus_rvalid;
    logic                      vblank, hblank, active;
    logic                      run = 1'b0;
    logic [1:0]                pol = 2'h0;
    logic                      pf_en, pf_rst, ip_en, ip_rst;
    logic [LW-1:0]             neigh, same;
    logic [1:0]                phase, spol;
    logic [TW*`NUM_TIMING-1:0] used;
    logic [31:0]               expq [$];
    logic [31:0]               val [13];
    logic [11:0]               ofs [13] = '{`OFS_USER_FIRST_COL, `OFS_USER_LAST_COL, `OFS_USER_FIRST_ROW,
        `OFS_USER_LAST_ROW, `OFS_USER_ROW_COUNT, `OFS_USER_COL_COUNT, `OFS_USER_VBLANK_LINES,
        `OFS_USER_HBLANK_LEAD, `OFS_USER_HBLANK_TRAIL, `OFS_USER_SYNC_POLARITY, `OFS_MOSAIC_PHASE,
        `OFS_PIXFIX_NEIGH_LIMIT, `OFS_PIXFIX_SAME_LIMIT};
    int                        n_fail = 0;
    int                        checks = 0;
    int                        cycles = 0;

    always #5 clk_sys = ~clk_sys;

    pixel_fix_timing_regs #(.TW(TW), .LW(LW)) pixel_fix_timing_regs_i (.CLK_SYS(clk_sys), .NRST(nrst),
        .BUS_ADDR(bus_addr), .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
        .BUS_RVALID(bus_rvalid), .VBLANK_IN(vblank), .HBLANK_IN(hblank), .ACTIVE_VIDEO_IN(active),
        .PIXFIX_ENABLE(pf_en), .PIXFIX_RESET(pf_rst), .NEIGHBOUR_LIMIT(neigh), .SAMECOLOUR_LIMIT(same),
        .INTERP_ENABLE(ip_en), .INTERP_RESET(ip_rst), .MOSAIC_PHASE(phase), .SYNC_POLARITY(spol),
        .USED_TIMING(used));
    video_source_model video_source_model_i (.clk(clk_sys), .run(run), .pol(pol), .vblank(vblank),
        .hblank(hblank), .active(active));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    function automatic logic [31:0] msk(input int i);
        return (i < 9) ? 32'((1 << TW) - 1) : (i < 11) ? 32'h3 : 32'((1 << LW) - 1);
    endfunction : msk

    // ----------------------------------------
    // bus cycles and video runs
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        @(negedge clk_sys);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        @(posedge clk_sys);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(negedge clk_sys);
    endtask : rd

    task automatic frames(input logic [1:0] p);
        @(posedge clk_sys);
        pol <= p;
        run <= 1'b1;
        repeat (800) @(posedge clk_sys);
        run <= 1'b0;
        @(negedge clk_sys);
    endtask : frames

    // monitor and watchdog
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (bus_rvalid === 1'b1)
            check(bus_rdata, expq.size() > 0 ? expq.pop_front() : 32'hXXXX_XXXX);
        if (cycles == 6000)
        begin
            n_fail++;
            summarize();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [1:0]  p1;
        logic [1:0]  p2;
        void'($urandom(32'h032C));
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check(32'(pf_en), 32'h1);
        check(32'(ip_rst), 32'h0);
        rd(`OFS_INTERP_CONTROL, `RST_CONTROL);
        rd(`OFS_INTERP_SOFT_RESET, `RST_SOFT_RESET);
        rd(`OFS_PIXFIX_CONTROL, `RST_CONTROL);
        rd(`OFS_PIXFIX_SOFT_RESET, `RST_SOFT_RESET);
        for (int i = 0; i < 13; i++)
        begin
            d = $urandom();
            val[i] = d & msk(i);
            wr(ofs[i], d);
        end
        wr(`OFS_INTERP_IRQ_CONTROL, d);
        rd(`OFS_INTERP_IRQ_CONTROL, d);
        for (int i = 0; i < 13; i++)
            rd(ofs[i], val[i]);
        check(32'(neigh), val[11]);
        check(32'(same), val[12]);
        check(32'(spol), val[9]);
        check(32'(phase), val[10]);
        // read-only and unmapped places
        wr(`OFS_USED_FIRST_COL, 32'hFFFF_FFFF);
        rd(`OFS_USED_FIRST_COL, 32'h0);
        wr(12'h881, 32'h0000_0FFF);
        rd(`OFS_PIXFIX_NEIGH_LIMIT, val[11]);
        rd(12'h881, 32'h0);
        rd(12'h8B8, 32'h0);
        // control and reset bits
        wr(`OFS_PIXFIX_CONTROL, 32'h0000_0002);
        check(32'(pf_en), 32'h0);
        rd(`OFS_PIXFIX_CONTROL, 32'h0000_0002);
        wr(`OFS_PIXFIX_SOFT_RESET, 32'h0000_0001);
        check(32'(pf_rst), 32'h1);
        wr(`OFS_INTERP_SOFT_RESET, 32'h0000_0001);
        check(32'(ip_rst), 32'h1);
        wr(`OFS_INTERP_SOFT_RESET, 32'h0000_0000);
        wr(`OFS_INTERP_CONTROL, 32'h0000_0001);
        check(32'(ip_en), 32'h1);
        // update in progress: nothing loads
        p1 = 2'($urandom());
        p2 = ~p1;
        frames(p1);
        rd(`OFS_MEAS_SYNC_POLARITY, 32'(p1));
        rd(`OFS_USED_LAST_COL, 32'h0);
        // update done: in-use copies follow
        wr(`OFS_INTERP_CONTROL, 32'h0000_0003);
        frames(p2);
        rd(`OFS_MEAS_SYNC_POLARITY, 32'(p2));
        rd(`OFS_INTERP_STATE, 32'(1 << `BIT_STATE_ENABLE | 1 << `BIT_STATE_DONE | 1 << `BIT_STATE_POL_H_SEEN
            | 1 << `BIT_STATE_POL_V_SEEN));
        for (int i = 0; i < 9; i++)
        begin
            rd(`OFS_USED_FIRST_COL + 12'(4 * i), val[i]);
            check(32'(used[i*TW +: TW]), val[i]);
        end
        repeat (4) @(posedge clk_sys);
        check(32'(expq.size()), 32'h0);
        summarize();
    end
endmodule : tb_top

bind pixel_fix_timing_regs pixfix_regs_properties #(.TW(TW), .LW(LW)) chk_i (.CLK_SYS, .NRST, .BUS_ADDR,
    .BUS_WR, .BUS_RD, .BUS_WDATA, .BUS_RVALID, .NEIGHBOUR_LIMIT, .SAMECOLOUR_LIMIT, .PIXFIX_ENABLE,
    .INTERP_RESET, .MOSAIC_PHASE, .SYNC_POLARITY);

// ==== bench/video_source_model.sv ====
// Purpose: sensor-side timing source for the bank's video inputs
// Assumes: 16 columns by 10 rows per frame
// Notes:   pol bit 1 vertical, bit 0 horizontal; 1 gives valid signalling
module video_source_model (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [1:0] pol,
    output logic            vblank,
    output logic            hblank,
    output logic            active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] col = 4'h0;
    logic [3:0] row = 4'h0;

    // ----------------------------------------
    // counters, frozen between runs
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (run)
        begin
            col <= col + 4'h1;
            if (col == 4'hF)
                row <= (row == 4'h9) ? 4'h0 : row + 4'h1;
        end
    end

    // active stays inside the non-blank area
    assign hblank = (col >= 4'hC) ^ pol[0];
    assign vblank = (row >= 4'h8) ^ pol[1];
    assign active = run && col >= 4'h2 && col < 4'hC && row >= 4'h1 && row < 4'h8;
endmodule : video_source_model

// ==== design/pixel_fix_timing_regs.sv ====
// Purpose: register bank for pixel-fix thresholds and interpolation timing
// Assumes: processor bus and video inputs; video inputs are resynchronised
// Notes:   read data is registered, one cycle after the read strobe
`include "pixfix_consts.svh"

// Behaviour
// - registers are memory-mapped at fixed offsets from the block base.
// - each register is decoded at its own offset, never by sequence position.
// - control bit 1 is a write-done flag; in-use copies load only when set.
// - read/write threshold for other-colour nearest neighbours at 0x880.
// - read/write threshold for same-colour neighbours at 0x884.
// - user polarity holds vertical in bit 1, horizontal in bit 0; 1 means valid.
// - measured polarities readable at 0x8B0 with the same layout and encoding.
// - phase register bit 0 horizontal, bit 1 vertical, picks top-left sample colour.
// - read/write user timing registers for active, total and blank values.
// - read-only in-use timing values at offsets separate from the user copies.
// - blanking is active low if active video is high during its high period.
// - active coordinates count from 0, total rows and columns from 1.
module pixel_fix_timing_regs #(
    parameter int           TW           = 16,
    parameter int           LW           = 12,
    parameter logic [31:0]  DEF_TIMING   = 32'h0000_0000,
    parameter logic [31:0]  DEF_LIMIT    = 32'h0000_0000,
    parameter logic [31:0]  DEF_IRQ      = 32'h0000_0000,
    parameter logic [1:0]   DEF_POLARITY = 2'h0,
    parameter logic [1:0]   DEF_PHASE    = 2'h0
) (
    input  wire logic           CLK_SYS,
    input  wire logic           NRST,
    input  wire logic [11:0]    BUS_ADDR,
    input  wire logic           BUS_WR,
    input  wire logic           BUS_RD,
    input  wire logic [31:0]    BUS_WDATA,
    output logic      [31:0]    BUS_RDATA,
    output logic                BUS_RVALID,
    input  wire logic           VBLANK_IN,
    input  wire logic           HBLANK_IN,
    input  wire logic           ACTIVE_VIDEO_IN,
    output logic                PIXFIX_ENABLE,
    output logic                PIXFIX_RESET,
    output logic      [LW-1:0]  NEIGHBOUR_LIMIT,
    output logic      [LW-1:0]  SAMECOLOUR_LIMIT,
    output logic                INTERP_ENABLE,
    output logic                INTERP_RESET,
    output logic      [1:0]     MOSAIC_PHASE,
    output logic      [1:0]     SYNC_POLARITY,
    output logic      [TW*`NUM_TIMING-1:0] USED_TIMING
);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic pixfix_pkg::reg_hit_t decode(input logic [11:0] a);
        pixfix_pkg::reg_hit_t h;
        h.sel = pixfix_pkg::SEL_NONE;
        h.idx = 4'h0;
        case (a)
            `OFS_INTERP_CONTROL     : h.sel = pixfix_pkg::SEL_INTERP_CONTROL;
            `OFS_INTERP_SOFT_RESET  : h.sel = pixfix_pkg::SEL_INTERP_SOFT_RESET;
            `OFS_INTERP_IRQ_CONTROL : h.sel = pixfix_pkg::SEL_INTERP_IRQ_CONTROL;
            `OFS_USER_FIRST_COL     : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h0};
            `OFS_USER_LAST_COL      : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h1};
            `OFS_USER_FIRST_ROW     : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h2};
            `OFS_USER_LAST_ROW      : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h3};
            `OFS_USER_ROW_COUNT     : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h4};
            `OFS_USER_COL_COUNT     : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h5};
            `OFS_USER_VBLANK_LINES  : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h6};
            `OFS_USER_HBLANK_LEAD   : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h7};
            `OFS_USER_HBLANK_TRAIL  : h = '{pixfix_pkg::SEL_USER_TIMING, 4'h8};
            `OFS_USER_SYNC_POLARITY : h.sel = pixfix_pkg::SEL_USER_SYNC_POLARITY;
            `OFS_MOSAIC_PHASE       : h.sel = pixfix_pkg::SEL_MOSAIC_PHASE;
            `OFS_PIXFIX_CONTROL     : h.sel = pixfix_pkg::SEL_PIXFIX_CONTROL;
            `OFS_PIXFIX_SOFT_RESET  : h.sel = pixfix_pkg::SEL_PIXFIX_SOFT_RESET;
            `OFS_PIXFIX_NEIGH_LIMIT : h.sel = pixfix_pkg::SEL_PIXFIX_NEIGH_LIMIT;
            `OFS_PIXFIX_SAME_LIMIT  : h.sel = pixfix_pkg::SEL_PIXFIX_SAME_LIMIT;
            `OFS_INTERP_STATE       : h.sel = pixfix_pkg::SEL_INTERP_STATE;
            `OFS_USED_FIRST_COL     : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h0};
            `OFS_USED_LAST_COL      : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h1};
            `OFS_USED_FIRST_ROW     : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h2};
            `OFS_USED_LAST_ROW      : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h3};
            `OFS_USED_ROW_COUNT     : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h4};
            `OFS_USED_COL_COUNT     : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h5};
            `OFS_USED_VBLANK_LINES  : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h6};
            `OFS_USED_HBLANK_LEAD   : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h7};
            `OFS_USED_HBLANK_TRAIL  : h = '{pixfix_pkg::SEL_USED_TIMING, 4'h8};
            `OFS_MEAS_SYNC_POLARITY : h.sel = pixfix_pkg::SEL_MEAS_SYNC_POLARITY;
            default                 : h.sel = pixfix_pkg::SEL_NONE;
        endcase
        return h;
    endfunction : decode

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // write side
    // ----------------------------------------
    pixfix_pkg::reg_hit_t wr_hit;
    pixfix_pkg::reg_hit_t rd_hit;
    logic                 wr_en;

    assign wr_hit = decode(BUS_ADDR);
    assign rd_hit = wr_hit;
    assign wr_en  = BUS_WR;

    logic [1:0]     pix_ctrl_q;
    logic           pix_rst_q;
    logic [1:0]     int_ctrl_q;
    logic           int_rst_q;
    logic [31:0]    irq_ctrl_q;
    logic [LW-1:0]  neigh_q;
    logic [LW-1:0]  same_q;
    logic [1:0]     user_pol_q;
    logic [1:0]     phase_q;
    logic [TW-1:0]  user_q [`NUM_TIMING];
    logic [TW-1:0]  used_q [`NUM_TIMING];

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pix_ctrl_q <= 2'(`RST_CONTROL);
            pix_rst_q  <= 1'b0;
            int_ctrl_q <= 2'(`RST_CONTROL);
            int_rst_q  <= 1'b0;
        end
        else if (wr_en)
        begin
            case (wr_hit.sel)
                pixfix_pkg::SEL_PIXFIX_CONTROL    : pix_ctrl_q <= BUS_WDATA[1:0];
                pixfix_pkg::SEL_PIXFIX_SOFT_RESET : pix_rst_q  <= BUS_WDATA[`BIT_SOFT_RESET];
                pixfix_pkg::SEL_INTERP_CONTROL    : int_ctrl_q <= BUS_WDATA[1:0];
                pixfix_pkg::SEL_INTERP_SOFT_RESET : int_rst_q  <= BUS_WDATA[`BIT_SOFT_RESET];
                default                           : ;
            endcase
        end
    end

    // ----------------------------------------
    // threshold, polarity and phase storage
    // ----------------------------------------

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_ctrl_q <= DEF_IRQ;
            neigh_q    <= DEF_LIMIT[LW-1:0];
            same_q     <= DEF_LIMIT[LW-1:0];
            user_pol_q <= DEF_POLARITY;
            phase_q    <= DEF_PHASE;
        end
        else if (wr_en)
        begin
            case (wr_hit.sel)
                pixfix_pkg::SEL_INTERP_IRQ_CONTROL : irq_ctrl_q <= BUS_WDATA;
                pixfix_pkg::SEL_PIXFIX_NEIGH_LIMIT : neigh_q    <= BUS_WDATA[LW-1:0];
                pixfix_pkg::SEL_PIXFIX_SAME_LIMIT  : same_q     <= BUS_WDATA[LW-1:0];
                pixfix_pkg::SEL_USER_SYNC_POLARITY : user_pol_q <= BUS_WDATA[1:0];
                pixfix_pkg::SEL_MOSAIC_PHASE       : phase_q    <= BUS_WDATA[1:0];
                default                            : ;
            endcase
        end
    end

    // ----------------------------------------
    // video inputs and polarity detection
    // ----------------------------------------
    logic [2:0] vid_meta_q;
    logic [2:0] vid_q;
    logic [1:0] meas_pol_q;
    logic [1:0] pol_seen_q;
    logic       vblank_norm_q;
    logic       frame_start;
    logic       interp_hold;
    logic       load_used;

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vid_meta_q <= 3'h0;
            vid_q      <= 3'h0;
        end
        else
        begin
            vid_meta_q <= {VBLANK_IN, HBLANK_IN, ACTIVE_VIDEO_IN};
            vid_q      <= vid_meta_q;
        end
    end

    assign interp_hold = int_rst_q;

    // ----------------------------------------
    // measured polarity
    // ----------------------------------------

    // bit 1 vertical, bit 0 horizontal, 1 means valid signalling
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meas_pol_q <= 2'h0;
            pol_seen_q <= 2'h0;
        end
        else if (interp_hold)
        begin
            meas_pol_q <= 2'h0;
            pol_seen_q <= 2'h0;
        end
        else if (vid_q[0])
        begin
            meas_pol_q <= vid_q[2:1];
            pol_seen_q <= 2'h3;
        end
    end

    // ----------------------------------------
    // frame start
    // ----------------------------------------

    // frame top-left: vertical blanking leaves its blank state
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            vblank_norm_q <= 1'b0;
        else
            vblank_norm_q <= vid_q[2] ^ meas_pol_q[`BIT_POL_V];
    end
    assign frame_start = vblank_norm_q & ~(vid_q[2] ^ meas_pol_q[`BIT_POL_V]);

    // in-use copies follow only once the update is marked done
    assign load_used = !interp_hold && int_ctrl_q[`BIT_ENABLE]
                       && int_ctrl_q[`BIT_WRITE_DONE] && frame_start;

    // ----------------------------------------
    // user and in-use timing copies
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_TIMING; gi++)
        begin : g_timing
            always_ff @(posedge CLK_SYS or negedge rst_n)
            begin
                if (!rst_n)
                    user_q[gi] <= DEF_TIMING[TW-1:0];
                else if (wr_en && wr_hit.sel == pixfix_pkg::SEL_USER_TIMING && wr_hit.idx == 4'(gi))
                    user_q[gi] <= BUS_WDATA[TW-1:0];
            end

            always_ff @(posedge CLK_SYS or negedge rst_n)
            begin
                if (!rst_n)
                    used_q[gi] <= DEF_TIMING[TW-1:0];
                else if (load_used)
                    used_q[gi] <= user_q[gi];
            end

            assign USED_TIMING[gi*TW +: TW] = used_q[gi];
        end
    endgenerate

    // ----------------------------------------
    // read side
    // ----------------------------------------
    logic [31:0] rd_d;
    logic [31:0] state_word;

    // ----------------------------------------
    // status word
    // ----------------------------------------

    always_comb
    begin
        state_word                         = 32'h0000_0000;
        state_word[`BIT_STATE_ENABLE]      = int_ctrl_q[`BIT_ENABLE];
        state_word[`BIT_STATE_DONE]        = int_ctrl_q[`BIT_WRITE_DONE];
        state_word[`BIT_STATE_POL_H_SEEN]  = pol_seen_q[`BIT_POL_H];
        state_word[`BIT_STATE_POL_V_SEEN]  = pol_seen_q[`BIT_POL_V];
        state_word[`BIT_STATE_IN_RESET]    = int_rst_q;
    end

    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (rd_hit.sel)
            pixfix_pkg::SEL_INTERP_CONTROL     : rd_d[1:0]    = int_ctrl_q;
            pixfix_pkg::SEL_INTERP_SOFT_RESET  : rd_d[0]      = int_rst_q;
            pixfix_pkg::SEL_INTERP_IRQ_CONTROL : rd_d         = irq_ctrl_q;
            pixfix_pkg::SEL_USER_TIMING        : rd_d[TW-1:0] = user_q[rd_hit.idx];
            pixfix_pkg::SEL_USER_SYNC_POLARITY : rd_d[1:0]    = user_pol_q;
            pixfix_pkg::SEL_MOSAIC_PHASE       : rd_d[1:0]    = phase_q;
            pixfix_pkg::SEL_PIXFIX_CONTROL     : rd_d[1:0]    = pix_ctrl_q;
            pixfix_pkg::SEL_PIXFIX_SOFT_RESET  : rd_d[0]      = pix_rst_q;
            pixfix_pkg::SEL_PIXFIX_NEIGH_LIMIT : rd_d[LW-1:0] = neigh_q;
            pixfix_pkg::SEL_PIXFIX_SAME_LIMIT  : rd_d[LW-1:0] = same_q;
            pixfix_pkg::SEL_INTERP_STATE       : rd_d         = state_word;
            pixfix_pkg::SEL_USED_TIMING        : rd_d[TW-1:0] = used_q[rd_hit.idx];
            pixfix_pkg::SEL_MEAS_SYNC_POLARITY : rd_d[1:0]    = meas_pol_q;
            default                            : rd_d         = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            BUS_RDATA  <= 32'h0000_0000;
            BUS_RVALID <= 1'b0;
        end
        else
        begin
            BUS_RVALID <= BUS_RD;
            if (BUS_RD)
                BUS_RDATA <= rd_d;
        end
    end

    // ----------------------------------------
    // outputs to the datapath
    // ----------------------------------------
    assign PIXFIX_ENABLE    = pix_ctrl_q[`BIT_ENABLE];
    assign PIXFIX_RESET     = pix_rst_q;
    assign NEIGHBOUR_LIMIT  = neigh_q;
    assign SAMECOLOUR_LIMIT = same_q;
    assign INTERP_ENABLE    = int_ctrl_q[`BIT_ENABLE];
    assign INTERP_RESET     = int_rst_q;
    assign MOSAIC_PHASE     = phase_q;
    assign SYNC_POLARITY    = user_pol_q;

endmodule : pixel_fix_timing_regs

// ==== design/pixfix_consts.svh ====
// Purpose: offsets, field positions and reset values of the pixel-fix/timing bank
// Assumes: byte offsets from the block base, 12-bit local address
// Notes:   definitions only
`ifndef PIXFIX_CONSTS_SVH
`define PIXFIX_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_INTERP_CONTROL      12'h838
`define OFS_INTERP_SOFT_RESET   12'h83C
`define OFS_INTERP_IRQ_CONTROL  12'h840
`define OFS_USER_FIRST_COL      12'h844
`define OFS_USER_LAST_COL       12'h848
`define OFS_USER_FIRST_ROW      12'h84C
`define OFS_USER_LAST_ROW       12'h850
`define OFS_USER_ROW_COUNT      12'h854
`define OFS_USER_COL_COUNT      12'h858
`define OFS_USER_VBLANK_LINES   12'h85C
`define OFS_USER_HBLANK_LEAD    12'h860
`define OFS_USER_HBLANK_TRAIL   12'h864
`define OFS_USER_SYNC_POLARITY  12'h868
`define OFS_MOSAIC_PHASE        12'h86C
`define OFS_PIXFIX_CONTROL      12'h878
`define OFS_PIXFIX_SOFT_RESET   12'h87C
`define OFS_PIXFIX_NEIGH_LIMIT  12'h880
`define OFS_PIXFIX_SAME_LIMIT   12'h884
`define OFS_INTERP_STATE        12'h888
`define OFS_USED_FIRST_COL      12'h88C
`define OFS_USED_LAST_COL       12'h890
`define OFS_USED_FIRST_ROW      12'h894
`define OFS_USED_LAST_ROW       12'h898
`define OFS_USED_ROW_COUNT      12'h89C
`define OFS_USED_COL_COUNT      12'h8A0
`define OFS_USED_VBLANK_LINES   12'h8A4
`define OFS_USED_HBLANK_LEAD    12'h8A8
`define OFS_USED_HBLANK_TRAIL   12'h8AC
`define OFS_MEAS_SYNC_POLARITY  12'h8B0

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define BIT_ENABLE              0
`define BIT_WRITE_DONE          1
`define BIT_SOFT_RESET          0
`define BIT_POL_H               0
`define BIT_POL_V               1
`define BIT_PHASE_X             0
`define BIT_PHASE_Y             1
`define BIT_STATE_ENABLE        0
`define BIT_STATE_DONE          1
`define BIT_STATE_POL_H_SEEN    2
`define BIT_STATE_POL_V_SEEN    3
`define BIT_STATE_IN_RESET      4
`define RST_CONTROL             32'h0000_0001
`define RST_SOFT_RESET          32'h0000_0000
`define NUM_TIMING              9

`endif

// ==== design/pixfix_pkg.sv ====
// Purpose: types of the pixel-fix/timing bank
// Assumes: constants come from pixfix_consts.svh
// Notes:   register selector produced by the address decoder
package pixfix_pkg;

    // ----------------------------------------
    // register selector
    // ----------------------------------------
    typedef enum logic [4:0] {
        SEL_NONE,
        SEL_INTERP_CONTROL,
        SEL_INTERP_SOFT_RESET,
        SEL_INTERP_IRQ_CONTROL,
        SEL_USER_TIMING,
        SEL_USER_SYNC_POLARITY,
        SEL_MOSAIC_PHASE,
        SEL_PIXFIX_CONTROL,
        SEL_PIXFIX_SOFT_RESET,
        SEL_PIXFIX_NEIGH_LIMIT,
        SEL_PIXFIX_SAME_LIMIT,
        SEL_INTERP_STATE,
        SEL_USED_TIMING,
        SEL_MEAS_SYNC_POLARITY
    } reg_sel_t;

    typedef struct packed {
        reg_sel_t   sel;
        logic [3:0] idx;
    } reg_hit_t;

endpackage : pixfix_pkg
